/* File: include/fsa_pkg.sv */
// constants shared by the flags and size attribute logic
//
// Behaviour
// - direction flag set decrements string pointers
// - set/clear direction instructions write direction flag
// - single-step flag enables step mode
// - interrupt enable flag gates maskable interrupts
// - io allowed when privilege level <= field
// - io field changes only by pop/return at 0
// - nested-task flag marks linked task
// - resume flag steers debug exception response
// - virtual-8086 flag enters virtual-8086 mode
// - alignment check needs flag and mask bit
// - virtual flags act only with extension bit
// - identification flag is program writable
// - wide flags: upper half reserved zero
// - pointer advances or reloads on transfers
// - pointer reachable only through call/return
// - wide pointer; relative address uses next pointer
// - protected mode default size follows d bit
// - real, v86, smm default sizes 16
// - 16-bit address size wraps offsets at 64k
// - 66h/67h toggle sizes, one instruction only
// - 64-bit mode: address 64, operand 32
// - wide operand bit forces 64, beats 66h
package fsa_pkg;
    // ------------------------------------------------------------
    // flag bit positions
    // ------------------------------------------------------------
    localparam int FSA_BIT_ALWAYS1 = 1;
    localparam int FSA_BIT_SSTEP = 8;
    localparam int FSA_BIT_IEN = 9;
    localparam int FSA_BIT_DIR = 10;
    localparam int FSA_BIT_IOPR_LO = 12;
    localparam int FSA_BIT_NEST = 14;
    localparam int FSA_BIT_RESUME = 16;
    localparam int FSA_BIT_V86 = 17;
    localparam int FSA_BIT_ALIGN = 18;
    localparam int FSA_BIT_VINT = 19;
    localparam int FSA_BIT_VPEND = 20;
    localparam int FSA_BIT_IDENT = 21;
    // writable system bits: 8..10, 12..14, 16..21
    localparam logic [31:0] FSA_SYS_MASK = 32'h003F7700;
    localparam logic [31:0] FSA_FLAGS_RESET = 32'h00000002;
    localparam logic [31:0] FSA_ADDR16_MASK = 32'h0000FFFF;
    // 32-bit address wrap for pointer and relative address
    localparam logic [31:0] FSA_ADDR32_MASK = 32'hFFFFFFFF;
    // io privilege field, bits 12 and 13
    localparam logic [31:0] FSA_IO_PRIVILEGE_FIELD_MASK = 32'h00003000;
    // upper half of the wide flags image, always reserved
    localparam logic [31:0] FSA_UPPER_ZERO = 32'h00000000;
    localparam logic [1:0] FSA_PL_KERNEL = 2'h0;
    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {FSA_SZ16, FSA_SZ32, FSA_SZ64} fsa_size_t;
    typedef enum logic [2:0] {
        FSA_MODE_REAL, FSA_MODE_PROT, FSA_MODE_V86, FSA_MODE_SMM,
        FSA_MODE_COMPAT, FSA_MODE_LONG64
    } fsa_mode_t;
    // flags update commands from execution
    typedef enum logic [2:0] {
        FSA_OP_NONE, FSA_OP_SET_DIR, FSA_OP_CLR_DIR, FSA_OP_POP, FSA_OP_INTERRUPT_RETURN_INSTR, FSA_OP_TASK
    } fsa_fop_t;
    // pointer commands
    typedef enum logic [1:0] {FSA_IP_HOLD, FSA_IP_STEP, FSA_IP_LOAD} fsa_ipop_t;
endpackage : fsa_pkg

/* File: design/fsa_size_decode.sv */
// operand and address size decode for one instruction
`timescale 1ns/100ps
`default_nettype none
module fsa_size_decode
    import fsa_pkg::*;
(
    input wire fsa_mode_t mode,
    input wire logic cs_default_big,
    input wire logic opsize_prefix,
    input wire logic addrsize_prefix,
    input wire logic wide_operand_prefix_bit,
    output fsa_size_t op_size,
    output fsa_size_t addr_size
);
    // ------------------------------------------------------------
    // default sizes per mode
    // ------------------------------------------------------------
    wire logic legacy16 = (mode == FSA_MODE_REAL) || (mode == FSA_MODE_V86)
        || (mode == FSA_MODE_SMM);
    wire logic is64 = (mode == FSA_MODE_LONG64);
    wire logic dflt32 = !legacy16 && cs_default_big;
    // prefix toggles apply only to this instruction's inputs
    wire logic op32 = dflt32 ^ opsize_prefix;
    wire logic ad32 = dflt32 ^ addrsize_prefix;
    // ------------------------------------------------------------
    // selection
    // ------------------------------------------------------------
    // 64-bit mode: wide bit beats 66h, 16-bit addressing not reachable
    assign op_size = is64 ? (wide_operand_prefix_bit ? FSA_SZ64 :
        (opsize_prefix ? FSA_SZ16 : FSA_SZ32)) : (op32 ? FSA_SZ32 : FSA_SZ16);
    assign addr_size = is64 ? (addrsize_prefix ? FSA_SZ32 : FSA_SZ64)
        : (ad32 ? FSA_SZ32 : FSA_SZ16);
endmodule : fsa_size_decode
`default_nettype wire

/* File: design/fsa_flags_core.sv */
// system flags, instruction pointer and size attribute logic
`timescale 1ns/100ps
`default_nettype none
module fsa_flags_core
    import fsa_pkg::*;
#(
    parameter int IP_W = 64
) (
    input wire logic clk,
    input wire logic reset_n,
    // execution side
    input wire fsa_mode_t mode,
    input wire logic [1:0] current_privilege_level,
    input wire fsa_fop_t flag_op,
    input wire logic [31:0] flag_wdata,
    input wire logic task_linked,
    input wire logic alignment_mask_bit,
    input wire logic virtual_mode_extension_bit,
    // instruction pointer side
    input wire fsa_ipop_t ip_op,
    input wire logic [3:0] instr_len,
    input wire logic [IP_W-1:0] ip_target,
    input wire logic [31:0] displacement,
    // per-instruction size attributes
    input wire logic cs_default_big,
    input wire logic opsize_prefix,
    input wire logic addrsize_prefix,
    input wire logic wide_operand_prefix_bit,
    // outputs
    output logic [63:0] wide_processor_flags,
    output logic string_step_down,
    output logic single_step_en,
    output logic maskable_int_en,
    output logic io_access_ok,
    output logic debug_resume,
    output logic v86_active,
    output logic align_check_en,
    output logic vint_active,
    output logic vint_pending,
    output logic [IP_W-1:0] return_address,
    output logic [IP_W-1:0] relative_address,
    output fsa_size_t op_size,
    output fsa_size_t addr_size
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (IP_W != 64) begin : g_bad_width
        $error("fsa_flags_core: pointer width must be 64");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] processor_flags; // 32-bit flags image
    logic [IP_W-1:0] instruction_pointer; // next instruction offset
    logic [31:0] next_flags;
    logic [IP_W-1:0] next_ip;
    fsa_size_t dec_op;
    fsa_size_t dec_addr;

    // ------------------------------------------------------------
    // flag update decode
    // ------------------------------------------------------------
    wire logic at_kernel = (current_privilege_level == FSA_PL_KERNEL);
    wire logic is_load = (flag_op == FSA_OP_POP) || (flag_op == FSA_OP_INTERRUPT_RETURN_INSTR);
    // io field writable only from privilege 0 by pop or return
    wire logic io_privilege_field_wr = is_load && at_kernel;
    wire logic [31:0] io_privilege_field_bits = FSA_IO_PRIVILEGE_FIELD_MASK;
    wire logic [31:0] load_mask = io_privilege_field_wr ? FSA_SYS_MASK : (FSA_SYS_MASK & ~io_privilege_field_bits);
    wire logic [31:0] loaded = (processor_flags & ~load_mask) | (flag_wdata & load_mask);

    // next flag image; always-one bit forced, reserved bits zero
    always_comb begin
        next_flags = processor_flags;
        unique case (flag_op)
            FSA_OP_NONE: next_flags = processor_flags;
            FSA_OP_SET_DIR: next_flags[FSA_BIT_DIR] = 1'b1;
            FSA_OP_CLR_DIR: next_flags[FSA_BIT_DIR] = 1'b0;
            FSA_OP_POP, FSA_OP_INTERRUPT_RETURN_INSTR: next_flags = loaded;
            FSA_OP_TASK: next_flags[FSA_BIT_NEST] = task_linked;
            default: next_flags = processor_flags;
        endcase
        next_flags = (next_flags & FSA_SYS_MASK) | FSA_FLAGS_RESET;
    end

    // flags register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            processor_flags <= FSA_FLAGS_RESET;
        end else begin
            processor_flags <= next_flags;
        end
    end

    // ------------------------------------------------------------
    // instruction pointer
    // ------------------------------------------------------------
    // no software port reaches the pointer; only steps and loads
    wire logic [IP_W-1:0] ip_stepped = instruction_pointer + IP_W'(instr_len);
    wire logic [IP_W-1:0] ip_raw = (ip_op == FSA_IP_LOAD) ? ip_target :
        (ip_op == FSA_IP_STEP) ? ip_stepped : instruction_pointer;
    // outside 64-bit mode the pointer wraps at its address size
    wire logic [IP_W-1:0] ip_mask = (mode == FSA_MODE_LONG64) ? {IP_W{1'b1}} :
        (dec_addr == FSA_SZ16) ? IP_W'(FSA_ADDR16_MASK) : IP_W'(FSA_ADDR32_MASK);
    assign next_ip = ip_raw & ip_mask;

    // pointer register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            instruction_pointer <= '0;
        end else begin
            instruction_pointer <= next_ip;
        end
    end

    // ------------------------------------------------------------
    // size decode
    // ------------------------------------------------------------
    fsa_size_decode u_dec (
        .mode(mode),
        .cs_default_big(cs_default_big),
        .opsize_prefix(opsize_prefix),
        .addrsize_prefix(addrsize_prefix),
        .wide_operand_prefix_bit(wide_operand_prefix_bit),
        .op_size(dec_op),
        .addr_size(dec_addr)
    );

    // ------------------------------------------------------------
    // derived controls, combinational before registering
    // ------------------------------------------------------------
    wire logic [1:0] io_field = processor_flags[FSA_BIT_IOPR_LO +: 2];
    wire logic c_io_ok = (current_privilege_level <= io_field);
    wire logic c_align = processor_flags[FSA_BIT_ALIGN] && alignment_mask_bit;
    wire logic c_vint = processor_flags[FSA_BIT_VINT] && virtual_mode_extension_bit;
    wire logic c_vpend = processor_flags[FSA_BIT_VPEND] && virtual_mode_extension_bit;
    // displacement sign-extended, added to the next instruction pointer
    wire logic [IP_W-1:0] disp_ext = {{(IP_W-32){displacement[31]}}, displacement};
    wire logic [IP_W-1:0] rel_sum = next_ip + disp_ext;
    wire logic [IP_W-1:0] rel_mask = (dec_addr == FSA_SZ64) ? {IP_W{1'b1}} :
        (dec_addr == FSA_SZ32) ? IP_W'(FSA_ADDR32_MASK) : IP_W'(FSA_ADDR16_MASK);

    // registered outputs: every output from a flip-flop
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wide_processor_flags <= {FSA_UPPER_ZERO, FSA_FLAGS_RESET};
            string_step_down <= 1'b0;
            single_step_en <= 1'b0;
            maskable_int_en <= 1'b0;
            io_access_ok <= 1'b0;
            debug_resume <= 1'b0;
            v86_active <= 1'b0;
            align_check_en <= 1'b0;
            vint_active <= 1'b0;
            vint_pending <= 1'b0;
            return_address <= '0;
            relative_address <= '0;
            op_size <= FSA_SZ16;
            addr_size <= FSA_SZ16;
        end else begin
            wide_processor_flags <= {FSA_UPPER_ZERO, processor_flags};
            string_step_down <= processor_flags[FSA_BIT_DIR];
            single_step_en <= processor_flags[FSA_BIT_SSTEP];
            maskable_int_en <= processor_flags[FSA_BIT_IEN];
            io_access_ok <= c_io_ok;
            debug_resume <= processor_flags[FSA_BIT_RESUME];
            v86_active <= processor_flags[FSA_BIT_V86];
            align_check_en <= c_align;
            vint_active <= c_vint;
            vint_pending <= c_vpend;
            return_address <= next_ip;
            relative_address <= rel_sum & rel_mask;
            op_size <= dec_op;
            addr_size <= dec_addr;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    dir_set_a: assert property (@(posedge clk) disable iff (!reset_n)
        flag_op == FSA_OP_SET_DIR |=> ##1 string_step_down)
        else $error("direction set not seen");
    dir_clr_a: assert property (@(posedge clk) disable iff (!reset_n)
        flag_op == FSA_OP_CLR_DIR |=> ##1 !string_step_down)
        else $error("direction clear not seen");
    io_privilege_field_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !(is_load && at_kernel) |=> $stable(processor_flags[FSA_BIT_IOPR_LO +: 2]))
        else $error("io field changed illegally");
    io_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        io_access_ok |-> $past(current_privilege_level) <= $past(io_field))
        else $error("io allowed above field");
    align_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        align_check_en |-> $past(alignment_mask_bit))
        else $error("alignment check without mask bit");
    vint_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        (vint_active || vint_pending) |-> $past(virtual_mode_extension_bit))
        else $error("virtual flag without extension");
    upper_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        wide_processor_flags == {FSA_UPPER_ZERO, $past(processor_flags)})
        else $error("wide flags image wrong");
    // privileged load copies the io field from the written image
    io_privilege_field_load_a: assert property (@(posedge clk) disable iff (!reset_n)
        (is_load && at_kernel) |=> processor_flags[FSA_BIT_IOPR_LO +: 2]
        == $past(flag_wdata[FSA_BIT_IOPR_LO +: 2]))
        else $error("io field not loaded");
    // nested bit follows the task link on a task command
    nest_a: assert property (@(posedge clk) disable iff (!reset_n)
        flag_op == FSA_OP_TASK |=> processor_flags[FSA_BIT_NEST] == $past(task_linked))
        else $error("nested bit not written");
    // identification bit must toggle under software control
    ident_a: assert property (@(posedge clk) disable iff (!reset_n)
        is_load |=> processor_flags[FSA_BIT_IDENT] == $past(flag_wdata[FSA_BIT_IDENT]))
        else $error("identification bit not writable");
    // step flag output mirrors the stored bit one edge later
    sstep_out_a: assert property (@(posedge clk) disable iff (!reset_n)
        single_step_en == $past(processor_flags[FSA_BIT_SSTEP]))
        else $error("step output wrong");
    // interrupt enable output mirrors the stored bit
    ien_out_a: assert property (@(posedge clk) disable iff (!reset_n)
        maskable_int_en == $past(processor_flags[FSA_BIT_IEN]))
        else $error("interrupt enable output wrong");
    // resume output mirrors the stored bit
    resume_out_a: assert property (@(posedge clk) disable iff (!reset_n)
        debug_resume == $past(processor_flags[FSA_BIT_RESUME]))
        else $error("resume output wrong");
    // virtual-8086 output mirrors the stored bit
    v86_out_a: assert property (@(posedge clk) disable iff (!reset_n)
        v86_active == $past(processor_flags[FSA_BIT_V86]))
        else $error("v86 output wrong");
    // a load in 64-bit mode takes the target unmasked
    ip_load_a: assert property (@(posedge clk) disable iff (!reset_n)
        (ip_op == FSA_IP_LOAD && mode == FSA_MODE_LONG64)
        |=> instruction_pointer == $past(ip_target))
        else $error("pointer not loaded");
    // 64-bit relative address is next pointer plus displacement
    rel_sum_a: assert property (@(posedge clk) disable iff (!reset_n)
        dec_addr == FSA_SZ64 |=> relative_address == $past(next_ip) + $past(disp_ext))
        else $error("relative address wrong");
    // compatibility mode address size follows the d bit when no address prefix is given
    compat_addr_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == FSA_MODE_COMPAT && !addrsize_prefix)
        |=> addr_size == ($past(cs_default_big) ? FSA_SZ32 : FSA_SZ16))
        else $error("compatibility address size wrong");
    ip_step_a: assert property (@(posedge clk) disable iff (!reset_n)
        (ip_op == FSA_IP_STEP && mode == FSA_MODE_LONG64)
        |=> instruction_pointer == $past(instruction_pointer) + IP_W'($past(instr_len)))
        else $error("pointer did not advance");
    legacy16_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == FSA_MODE_REAL && !opsize_prefix && !addrsize_prefix)
        |=> op_size == FSA_SZ16 && addr_size == FSA_SZ16)
        else $error("real mode default not 16");
    wide_op_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == FSA_MODE_LONG64 && wide_operand_prefix_bit) |=> op_size == FSA_SZ64)
        else $error("wide bit did not force 64");
    no16_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == FSA_MODE_LONG64) |=> addr_size != FSA_SZ16)
        else $error("16-bit address in 64-bit mode");
    prot_d_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == FSA_MODE_PROT && !opsize_prefix)
        |=> op_size == ($past(cs_default_big) ? FSA_SZ32 : FSA_SZ16))
        else $error("protected default size wrong");
endmodule : fsa_flags_core
`default_nettype wire

/* File: tb/fsa_flags_core_tb.sv */
// self-checking testbench for the flags, pointer and size attribute core
`timescale 1ns/100ps
`default_nettype none
module fsa_flags_core_tb import fsa_pkg::*;;
    // ------------------------------------------------------------
    // stimulus and observation signals
    // ------------------------------------------------------------
    logic clk = 1'b0; // 20 mhz core clock
    logic reset_n = 1'b0; // held low for two cycles
    fsa_mode_t mode = FSA_MODE_PROT;
    logic [1:0] current_privilege_level = 2'h0;
    fsa_fop_t flag_op = FSA_OP_NONE; // idle between commands
    logic [31:0] flag_wdata = 32'h0;
    logic task_linked = 1'b0;
    logic alignment_mask_bit = 1'b0;
    logic virtual_mode_extension_bit = 1'b0;
    fsa_ipop_t ip_op = FSA_IP_HOLD;
    logic [3:0] instr_len = 4'h0;
    logic [63:0] ip_target = 64'h0;
    logic [31:0] displacement = 32'h0;
    logic cs_default_big = 1'b0;
    logic opsize_prefix = 1'b0;
    logic addrsize_prefix = 1'b0;
    logic wide_operand_prefix_bit = 1'b0;
    logic [63:0] wide_processor_flags, return_address, relative_address;
    logic string_step_down, single_step_en, maskable_int_en, io_access_ok, debug_resume;
    logic v86_active, align_check_en, vint_active, vint_pending;
    fsa_size_t op_size, addr_size;
    logic [8:0] outs; // all flag-derived levels, compared in one go
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0; // hang guard
    assign outs = {string_step_down, single_step_en, maskable_int_en, io_access_ok,
        debug_resume, v86_active, align_check_en, vint_active, vint_pending};
    fsa_flags_core #(.IP_W(64)) u_dut (.clk(clk), .reset_n(reset_n), .mode(mode),
        .current_privilege_level(current_privilege_level), .flag_op(flag_op),
        .flag_wdata(flag_wdata), .task_linked(task_linked),
        .alignment_mask_bit(alignment_mask_bit),
        .virtual_mode_extension_bit(virtual_mode_extension_bit), .ip_op(ip_op),
        .instr_len(instr_len), .ip_target(ip_target), .displacement(displacement),
        .cs_default_big(cs_default_big), .opsize_prefix(opsize_prefix),
        .addrsize_prefix(addrsize_prefix), .wide_operand_prefix_bit(wide_operand_prefix_bit),
        .wide_processor_flags(wide_processor_flags), .string_step_down(string_step_down),
        .single_step_en(single_step_en), .maskable_int_en(maskable_int_en),
        .io_access_ok(io_access_ok), .debug_resume(debug_resume), .v86_active(v86_active),
        .align_check_en(align_check_en), .vint_active(vint_active),
        .vint_pending(vint_pending), .return_address(return_address),
        .relative_address(relative_address), .op_size(op_size), .addr_size(addr_size));
    // ------------------------------------------------------------
    // clock, hang guard and shared tasks
    // ------------------------------------------------------------
    always #25 clk = ~clk;
    // generous ceiling: the whole run needs well under 400 cycles
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            miscompares = miscompares + 1;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // levels pass through one register stage; two edges leave margin
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    // one flag command; derived outputs land one edge after the register
    task automatic fop(input fsa_fop_t op, input logic [31:0] d);
        @(posedge clk);
        flag_op <= op;
        flag_wdata <= d;
        @(posedge clk);
        flag_op <= FSA_OP_NONE;
        @(posedge clk);
        #1;
    endtask : fop
    task automatic ipop(input fsa_ipop_t op, input logic [3:0] n, input logic [63:0] t);
        @(posedge clk);
        ip_op <= op;
        instr_len <= n;
        ip_target <= t;
        @(posedge clk);
        ip_op <= FSA_IP_HOLD;
        settle();
    endtask : ipop
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk(wide_processor_flags, 64'h2);
        chk(64'(outs), 64'h20);
        chk(return_address, 64'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_dir();
        fop(FSA_OP_SET_DIR, 32'h0);
        chk(wide_processor_flags, 64'h402);
        chk(64'(outs), 64'h120);
        fop(FSA_OP_CLR_DIR, 32'h0);
        chk(64'(outs), 64'h20);
        $display("test direction done");
    endtask : t_dir
    task automatic t_pop();
        fop(FSA_OP_POP, 32'hFFFFFFFF);
        chk(wide_processor_flags, 64'h3F7702);
        chk(64'(outs), 64'h1F8);
        @(posedge clk);
        alignment_mask_bit <= 1'b1;
        virtual_mode_extension_bit <= 1'b1;
        current_privilege_level <= 2'h3;
        settle();
        chk(64'(outs), 64'h1FF);
        fop(FSA_OP_POP, 32'h0);
        chk(wide_processor_flags, 64'h3002);
        chk(64'(outs), 64'h20);
        fop(FSA_OP_INTERRUPT_RETURN_INSTR, 32'h1000);
        chk(wide_processor_flags, 64'h3002);
        @(posedge clk);
        current_privilege_level <= 2'h0;
        fop(FSA_OP_INTERRUPT_RETURN_INSTR, 32'h1000);
        chk(wide_processor_flags, 64'h1002);
        @(posedge clk);
        current_privilege_level <= 2'h2;
        settle();
        chk(64'(io_access_ok), 64'h0);
        @(posedge clk);
        current_privilege_level <= 2'h1;
        settle();
        chk(64'(io_access_ok), 64'h1);
        $display("test system flags done");
    endtask : t_pop
    task automatic t_task();
        @(posedge clk);
        task_linked <= 1'b1;
        fop(FSA_OP_TASK, 32'h0);
        chk(wide_processor_flags, 64'h5002);
        @(posedge clk);
        task_linked <= 1'b0;
        fop(FSA_OP_TASK, 32'h0);
        chk(wide_processor_flags, 64'h1002);
        $display("test nested task done");
    endtask : t_task
    task automatic t_ip();
        @(posedge clk);
        mode <= FSA_MODE_LONG64;
        displacement <= 32'hFFFFFFF0;
        ipop(FSA_IP_LOAD, 4'h0, 64'h123456789ABCDEF0);
        chk(return_address, 64'h123456789ABCDEF0);
        chk(relative_address, 64'h123456789ABCDEE0);
        ipop(FSA_IP_STEP, 4'hF, 64'h0);
        ipop(FSA_IP_HOLD, 4'hF, 64'h0);
        chk(return_address, 64'h123456789ABCDEFF);
        @(posedge clk);
        mode <= FSA_MODE_PROT;
        displacement <= 32'h10;
        ipop(FSA_IP_LOAD, 4'h0, 64'h1FFFE);
        chk(return_address, 64'hFFFE);
        ipop(FSA_IP_STEP, 4'h4, 64'h0);
        chk(return_address, 64'h2);
        chk(relative_address, 64'h12);
        @(posedge clk);
        cs_default_big <= 1'b1;
        ipop(FSA_IP_LOAD, 4'h0, 64'hFFFFFFFFFFFFFFFC);
        ipop(FSA_IP_STEP, 4'h8, 64'h0);
        chk(return_address, 64'h4);
        $display("test pointer done");
    endtask : t_ip
    task automatic t_size();
        fsa_mode_t ms[6];
        fsa_size_t eo;
        fsa_size_t ea;
        ms = '{FSA_MODE_PROT, FSA_MODE_COMPAT, FSA_MODE_LONG64, FSA_MODE_REAL,
            FSA_MODE_V86, FSA_MODE_SMM};
        for (int m = 0; m < 6; m++) begin
            for (int i = 0; i < 8; i++) begin
                @(posedge clk);
                mode <= ms[m];
                cs_default_big <= (m != 2) && i[2];
                wide_operand_prefix_bit <= (m == 2) && i[2];
                opsize_prefix <= (m < 3) && i[1];
                addrsize_prefix <= (m < 3) && i[0];
                settle();
                // legacy modes get the d bit only, so defaults stay 16
                eo = (m < 2 && (i[2] ^ i[1])) ? FSA_SZ32 : FSA_SZ16;
                ea = (m < 2 && (i[2] ^ i[0])) ? FSA_SZ32 : FSA_SZ16;
                if (m == 2) begin
                    eo = i[2] ? FSA_SZ64 : (i[1] ? FSA_SZ16 : FSA_SZ32);
                    ea = i[0] ? FSA_SZ32 : FSA_SZ64;
                end
                chk(64'(op_size), 64'(eo));
                chk(64'(addr_size), 64'(ea));
            end
        end
        $display("test size attributes done");
    endtask : t_size
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        settle();
        t_reset();
        t_dir();
        t_pop();
        t_task();
        t_ip();
        t_size();
        report_and_stop();
    end
endmodule : fsa_flags_core_tb
`default_nettype wire
